// File: design/rf_config_pkg.sv
package rf_config_pkg;

	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_RSVD_A      = 6'h20;
	localparam logic [ADDR_W-1:0] ADDR_CRC_HIGH    = 6'h21;
	localparam logic [ADDR_W-1:0] ADDR_CRC_LOW     = 6'h22;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_B      = 6'h23;
	localparam logic [ADDR_W-1:0] ADDR_PULSE_WIDTH = 6'h24;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_C      = 6'h25;
	localparam logic [ADDR_W-1:0] ADDR_RX_CONFIG   = 6'h26;

	// reset values
	localparam logic [DATA_W-1:0] RST_RSVD_A      = 8'h00;
	localparam logic [DATA_W-1:0] RST_CRC         = 8'hff;
	localparam logic [DATA_W-1:0] RST_RSVD_B      = 8'h88;
	localparam logic [DATA_W-1:0] RST_PULSE_WIDTH = 8'h26;
	localparam logic [DATA_W-1:0] RST_RSVD_C      = 8'h87;
	localparam logic [DATA_W-1:0] RST_RX_CONFIG   = 8'h48;
	localparam logic [DATA_W-1:0] UNMAPPED_READ   = 8'h00;

	// receiver gain field
	localparam int GAIN_LSB = 4;
	localparam int GAIN_MSB = 6;
	localparam logic [DATA_W-1:0] GAIN_MASK = 8'h70;

	// gain in dB per code
	localparam logic [5:0] DB_18 = 6'd18;
	localparam logic [5:0] DB_23 = 6'd23;
	localparam logic [5:0] DB_33 = 6'd33;
	localparam logic [5:0] DB_38 = 6'd38;
	localparam logic [5:0] DB_43 = 6'd43;
	localparam logic [5:0] DB_48 = 6'd48;

	typedef struct packed {
		logic              write;
		logic              read;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] high;
		logic [DATA_W-1:0] low;
	} crc_result_t;

endpackage

// File: design/rx_gain_decode.sv
`timescale 1ns/1ns
module rx_gain_decode
	import rf_config_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [2:0] gainCode,
	output logic      [5:0] gainDb
);
	logic [5:0] gainDb_d;

	// codes 0 and 2 alias, as do 1 and 3
	always_comb begin
		case (gainCode)
			3'h0, 3'h2: gainDb_d = DB_18;
			3'h1, 3'h3: gainDb_d = DB_23;
			3'h4:       gainDb_d = DB_33;
			3'h5:       gainDb_d = DB_38;
			3'h6:       gainDb_d = DB_43;
			default:    gainDb_d = DB_48;
		endcase
	end

	// registered so the analog setting never glitches
	always_ff @(posedge clk) begin
		// reset field code 4 of the 48h reset image means 33 dB
		if (!resetn) gainDb <= DB_33;
		else gainDb <= gainDb_d;
	end

	a_gain_map: assert property (@(posedge clk) disable iff (!resetn)
		(gainCode == 3'h2) |=> (gainDb == DB_18))
		else $error("gain code 2 not 18 dB");
endmodule

// File: design/mod_pulse_gen.sv
`timescale 1ns/1ns
module mod_pulse_gen
	import rf_config_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              pulseStart,
	input  wire logic [DATA_W-1:0] pulseWidth,
	output logic                   pulseOut
);
	logic [DATA_W-1:0] count_q;
	logic [DATA_W-1:0] widthHeld_q;

	// copy of the width in force for the running pulse, for the length check
	always_ff @(posedge clk) begin
		if (!resetn) widthHeld_q <= '0;
		else if (pulseStart && !pulseOut) widthHeld_q <= pulseWidth;
	end

	// width is latched at start; a write mid-pulse affects the next pulse only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pulseOut <= 1'b0;
			count_q  <= '0;
		end else if (pulseStart && !pulseOut) begin
			pulseOut <= 1'b1;
			count_q  <= pulseWidth;
		end else if (pulseOut) begin
			if (count_q == '0) pulseOut <= 1'b0;
			else count_q <= count_q - 1'b1;
		end
	end

	logic [DATA_W:0] len_q;
	always_ff @(posedge clk) begin
		if (!resetn) len_q <= '0;
		else if (pulseOut) len_q <= len_q + 1'b1;
		else len_q <= '0;
	end

	a_pulse_len: assert property (@(posedge clk) disable iff (!resetn)
		$fell(pulseOut) |-> (len_q == ({1'b0, widthHeld_q} + 9'h001)))
		else $error("pulse length wrong");
endmodule

// File: design/crc_rf_config_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
// Notes on behaviour
// - crc result high byte at 21h, low byte at 22h, both read-only
// - both crc bytes read ffh after reset until a crc result loads
// - each modulation pulse lasts pulse width plus one carrier clock periods
// - pulse width register at 24h is read/write, resets to 26h
// - gain codes: 0,2 18dB; 1,3 23dB; 4 33; 5 38; 6 43; 7 48 dB
// - receiver config at 26h resets 48h; bits 6..4 rw, others reserved
// - reserved registers 20h, 23h, 25h hold 00h, 88h, 87h
module crc_rf_config_regs
	import rf_config_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic [rf_config_pkg::ADDR_W-1:0] addr,
	input  wire logic [rf_config_pkg::DATA_W-1:0] wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output logic      [rf_config_pkg::DATA_W-1:0] rdata,
	input  wire rf_config_pkg::crc_result_t crcIn,
	input  wire logic                       pulseStart,
	output logic                            pulseOut,
	output logic      [2:0]                 gainCode,
	output logic      [5:0]                 gainDb
);
	import rf_config_pkg::*;

	bus_req_t req;
	logic [DATA_W-1:0] crcHigh_q;
	logic [DATA_W-1:0] crcLow_q;
	logic [DATA_W-1:0] pulseWidth_q;
	logic [2:0]        gain_q;
	logic [DATA_W-1:0] rdata_d;

	assign req = '{write: wr, read: rd, addr: addr, wdata: wdata};

	// crc bytes load only from the engine; bus writes cannot reach them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			crcHigh_q <= RST_CRC;
			crcLow_q  <= RST_CRC;
		end else if (crcIn.valid) begin
			crcHigh_q <= crcIn.high;
			crcLow_q  <= crcIn.low;
		end
	end

	// pulse width register
	always_ff @(posedge clk) begin
		if (!resetn) pulseWidth_q <= RST_PULSE_WIDTH;
		else if (req.write && req.addr == ADDR_PULSE_WIDTH) pulseWidth_q <= req.wdata;
	end

	// only the gain field is stored; reserved bits keep reset value
	always_ff @(posedge clk) begin
		if (!resetn) gain_q <= RST_RX_CONFIG[GAIN_MSB:GAIN_LSB];
		else if (req.write && req.addr == ADDR_RX_CONFIG)
			gain_q <= req.wdata[GAIN_MSB:GAIN_LSB];
	end

	// read mux; reserved registers return constants
	always_comb begin
		case (req.addr)
			ADDR_RSVD_A:      rdata_d = RST_RSVD_A;
			ADDR_CRC_HIGH:    rdata_d = crcHigh_q;
			ADDR_CRC_LOW:     rdata_d = crcLow_q;
			ADDR_RSVD_B:      rdata_d = RST_RSVD_B;
			ADDR_PULSE_WIDTH: rdata_d = pulseWidth_q;
			ADDR_RSVD_C:      rdata_d = RST_RSVD_C;
			ADDR_RX_CONFIG:   rdata_d = (RST_RX_CONFIG & ~GAIN_MASK)
				| {1'b0, gain_q, 4'h0};
			default:          rdata_d = UNMAPPED_READ;
		endcase
	end

	// read data stand one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (!resetn) rdata <= '0;
		else if (req.read) rdata <= rdata_d;
		else rdata <= '0;
	end

	assign gainCode = gain_q;

	rx_gain_decode u_gain (
		.clk      (clk),
		.resetn   (resetn),
		.gainCode (gain_q),
		.gainDb   (gainDb)
	);

	mod_pulse_gen u_pulse (
		.clk        (clk),
		.resetn     (resetn),
		.pulseStart (pulseStart),
		.pulseWidth (pulseWidth_q),
		.pulseOut   (pulseOut)
	);

	a_crc_ro: assert property (@(posedge clk) disable iff (!resetn)
		(wr && addr == ADDR_CRC_HIGH && !crcIn.valid) |=> $stable(crcHigh_q))
		else $error("crc high changed by bus write");
	a_rsvd_read: assert property (@(posedge clk) disable iff (!resetn)
		(rd && addr == ADDR_RSVD_B) |=> (rdata == RST_RSVD_B))
		else $error("reserved 23h read wrong");
	a_width_wr: assert property (@(posedge clk) disable iff (!resetn)
		(wr && addr == ADDR_PULSE_WIDTH) ##1 (rd && addr == ADDR_PULSE_WIDTH && !wr)
		|=> (rdata == $past(wdata, 2)))
		else $error("pulse width readback wrong");
	a_cfg_rsvd: assert property (@(posedge clk) disable iff (!resetn)
		(rd && addr == ADDR_RX_CONFIG) |=> ((rdata & ~GAIN_MASK) == (RST_RX_CONFIG & ~GAIN_MASK)))
		else $error("reserved config bits not fixed");
endmodule

// File: testbench/test_crc_rf_config_regs.sv
`timescale 1ns/1ns
module test_crc_rf_config_regs;
	import rf_config_pkg::*;
	logic              clk        = 0;
	logic              resetn     = 0;
	logic [ADDR_W-1:0] addr       = '0;
	logic [DATA_W-1:0] wdata      = '0;
	logic              wr         = 0;
	logic              rd         = 0;
	crc_result_t       crcIn      = '0;
	logic              pulseStart = 0;
	logic [DATA_W-1:0] rdata;
	logic              pulseOut;
	logic [2:0]        gainCode;
	logic [5:0]        gainDb;
	int                miscompares = 0;
	int                checked     = 0;
	// reset image of 20h..26h, then one unmapped address
	logic [7:0] rstv [8] = '{8'h00, 8'hff, 8'hff, 8'h88, 8'h26, 8'h87, 8'h48, 8'h00};
	logic [5:0] dbTab [8] = '{DB_18, DB_23, DB_18, DB_23, DB_33, DB_38, DB_43, DB_48};
	// free-running 100 MHz clock
	always #5 clk = ~clk;
	crc_rf_config_regs crc_rf_config_regs_i (
		.clk       (clk),
		.resetn    (resetn),
		.addr      (addr),
		.wdata     (wdata),
		.wr        (wr),
		.rd        (rd),
		.rdata     (rdata),
		.crcIn     (crcIn),
		.pulseStart(pulseStart),
		.pulseOut  (pulseOut),
		.gainCode  (gainCode),
		.gainDb    (gainDb)
	);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe; the next access waits an edge so strobes never merge
	task automatic wr8(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	// read data only stand in the cycle after the strobe, so sample there
	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, exp);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic testReset();
		for (int i = 0; i < 8; i++) rdChk(6'h20 + 6'(i), rstv[i]);
		chk(8'(gainCode), 8'h04);
		chk(8'(gainDb), 8'(DB_33));
		$display("test reset done");
	endtask
	// write the inverse of every reset value; only writable bits may move
	task automatic testWrites();
		logic [7:0] e;
		for (int i = 0; i < 7; i++) wr8(6'h20 + 6'(i), ~rstv[i]);
		for (int i = 0; i < 7; i++) begin
			e = rstv[i];
			if (i == 4) e = ~rstv[i];
			if (i == 6) e = (rstv[i] & ~GAIN_MASK) | (~rstv[i] & GAIN_MASK);
			rdChk(6'h20 + 6'(i), e);
		end
		$display("test writes done");
	endtask
	task automatic testCrc();
		@(posedge clk);
		crcIn <= '{1'b1, 8'h12, 8'h34};
		@(posedge clk);
		crcIn <= '0;
		rdChk(ADDR_CRC_HIGH, 8'h12);
		rdChk(ADDR_CRC_LOW, 8'h34);
		$display("test crc done");
	endtask
	task automatic testGain();
		for (int c = 0; c < 8; c++) begin
			wr8(ADDR_RX_CONFIG, 8'h8f | 8'(c << 4));
			repeat (2) @(posedge clk);
			#1 chk(8'(gainCode), 8'(c));
			chk(8'(gainDb), 8'(dbTab[c]));
			rdChk(ADDR_RX_CONFIG, 8'h08 | 8'(c << 4));
		end
		$display("test gain done");
	endtask
	// write then read with no gap must already see the new value
	task automatic testBackToBack();
		@(posedge clk);
		addr <= ADDR_PULSE_WIDTH;
		wdata <= 8'h5a;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, 8'h5a);
		$display("test back to back done");
	endtask
	// widths at both ends of the field plus one in between; bench
	task automatic testPulse();
		logic [7:0] ws [3] = '{8'h00, 8'h05, 8'hff};
		int n;
		for (int k = 0; k < 3; k++) begin
			wr8(ADDR_PULSE_WIDTH, ws[k]);
			@(posedge clk);
			pulseStart <= 1;
			@(posedge clk);
			pulseStart <= 0;
			n = 0;
			for (int i = 0; i <= 600; i++) begin
				if (i == 600) begin
					miscompares++;
					$display("FAIL %0t pulse never ended", $time);
					tally_and_finish();
				end
				#1 if (pulseOut === 1'b1) n++;
				else if (n > 0) break;
				@(posedge clk);
			end
			chk(8'(n - 1), ws[k]);
		end
		$display("test pulse done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1;
		testReset();
		testWrites();
		testCrc();
		testGain();
		testBackToBack();
		testPulse();
		tally_and_finish();
	end
endmodule
